/* File: logic/pointer_subtract_indexed_decode.sv */
// Pointer subtract, subtract-and-return and indexed operand decode
//
// What this block does
// RULE_01: Subtract 6-bit literal from pointer 0, 1 or 2; flags untouched.
// RULE_02: Subtract-and-return subtracts its literal from frame pointer only.
// RULE_03: Subtract-and-return then loads PC from the return stack top.
// RULE_04: Subtract-and-return is one word, two cycles, second cycle a no-op.
// RULE_05: Pointer field 11 of the subtract encoding means subtract-and-return.
// RULE_06: Extended set enable also enables indexed literal offset addressing.
// RULE_07: Extension off: access bank when access bit 0, else selected bank.
// RULE_08: Extension on, access bit 0, address up to 5Fh: frame offset.
// RULE_09: Indexed mapping applies to all byte and bit operand instructions.
// RULE_10: Frame pointer 00h maps indexed offsets onto the access bank.
// RULE_11: Destination bit still picks working register or file register.
// RULE_12: Access bit 0 addresses above 5Fh stay literal access bank.
// RULE_13: Indexed address is the 12-bit sum of frame pointer and offset.
// RULE_14: Extension enable resets to 1, enabling extended set and indexing.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module pointer_subtract_indexed_decode (
   input wire logic hclk, // Core clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Slave ready
   output logic [31:0] hrdata, // Read data
   output logic hresp, // Always OKAY
   input wire logic instr_valid, // Instruction word offered
   input wire logic [15:0] instr_word, // Program word
   output logic instr_ready, // Word can be taken
   input wire logic [core_ext_pkg::PC_W-1:0] return_stack_top, // Return addr
   input wire logic [core_ext_pkg::BANK_W-1:0] bank_select_value, // Bank
   input wire logic opnd_valid, // Operand address to map
   input wire logic [7:0] opnd_addr, // File address field
   input wire logic opnd_access, // Access bit of the opcode
   input wire logic opnd_dest, // Destination bit of the opcode
   output logic map_valid, // Mapped address valid, one cycle
   output logic [core_ext_pkg::ADDR_W-1:0] map_addr, // Mapped address
   output logic map_indexed, // Address came from frame offset
   output logic map_to_wreg, // Result goes to working register
   output logic pc_load, // Program counter load pulse
   output logic [core_ext_pkg::PC_W-1:0] pc_value, // New program counter
   output logic [core_ext_pkg::ADDR_W-1:0] stack_frame_pointer, // Frame ptr
   output logic ext_enabled // Extended set active
);
   import core_ext_pkg::*;

   // ==========================================================
   // Bus decode
   // ==========================================================
   // Word registers decode on the low byte of the address only
   function automatic logic reg_hit(input logic [31:0] a,
                                    input logic [7:0] ofs);
      reg_hit = (a[7:0] == ofs);
   endfunction

   logic wr_pend_ff;
   logic [31:0] wr_addr_ff;
   logic rd_pend_ff;
   logic [31:0] rd_addr_ff;
   logic bus_take;
   logic bus_wr;
   logic wr_now;

   assign bus_take = hsel && hready && htrans[1];
   assign bus_wr = bus_take && hwrite;
   assign wr_now = wr_pend_ff && hready;

   // Transfer size is not decoded; masters must issue whole words
   // Zero wait states: every transfer finishes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
      end else if (hready) begin
         wr_pend_ff <= bus_wr;
         rd_pend_ff <= bus_take && !hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_addr_ff <= 32'h00000000;
         rd_addr_ff <= 32'h00000000;
      end else if (bus_take) begin
         wr_addr_ff <= haddr;
         rd_addr_ff <= haddr;
      end
   end

   logic wr_cfg;
   logic wr_retcnt;
   logic wr_subcnt;
   logic wr_mapcnt;

   assign wr_cfg = wr_now && reg_hit(wr_addr_ff, CFG_OFS);
   assign wr_retcnt = wr_now && reg_hit(wr_addr_ff, RETCNT_OFS);
   assign wr_subcnt = wr_now && reg_hit(wr_addr_ff, SUBCNT_OFS);
   assign wr_mapcnt = wr_now && reg_hit(wr_addr_ff, MAPCNT_OFS);

   // ==========================================================
   // Configuration
   // ==========================================================
   logic ext_en_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_en_ff <= CFG_EXT_RST; // RULE_14
      end else if (wr_cfg) begin
         ext_en_ff <= hwdata[CFG_EXT_BIT];
      end
   end

   // One bit turns on both the new opcodes and indexed operands
   assign ext_enabled = ext_en_ff; // RULE_06

   // ==========================================================
   // Instruction decode
   // ==========================================================
   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic instr_take;
   logic is_sub_op;
   logic is_return;
   logic is_sub_ptr;
   logic [1:0] ptr_sel;
   logic [ADDR_W-1:0] lit_wide;

   assign instr_ready = (state_ff == exec_st); // RULE_04
   assign instr_take = instr_valid && instr_ready;
   // With the extension off this opcode is not ours to execute
   assign is_sub_op = ext_en_ff && (instr_word[15:8] == OPC_SUB_PTR);
   assign ptr_sel = instr_word[SEL_MSB:SEL_LSB];
   assign is_return = is_sub_op && (ptr_sel == SEL_RETURN); // RULE_05
   assign is_sub_ptr = is_sub_op && (ptr_sel != SEL_RETURN); // RULE_01
   assign lit_wide = {6'h00, instr_word[LIT_MSB:0]};

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         exec_st: begin
            if (instr_take && is_return) begin
               nxt_state = ret_nop_st; // RULE_04
            end
         end
         ret_nop_st: begin
            // Second cycle does nothing but let the new fetch settle
            nxt_state = exec_st; // RULE_04
         end
         default: begin
            nxt_state = exec_st;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= exec_st;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Pointer file
   // ==========================================================
   // Instruction updates win over a bus write in the same cycle
   logic [ADDR_W-1:0] ptr_ff [NUM_PTR];
   logic [ADDR_W-1:0] nxt_ptr [NUM_PTR];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
         logic sub_hit;
         logic bus_hit;
         assign sub_hit = instr_take && ((is_sub_ptr &&
            (ptr_sel == 2'(gi))) || (is_return &&
            (gi == int'(SEL_FRAME)))); // RULE_01 RULE_02
         assign bus_hit = wr_now && reg_hit(wr_addr_ff,
            8'(PTR0_OFS + 8'(gi) * PTR_STRIDE));
         // Plain wrap-around subtract; no status flags are produced
         assign nxt_ptr[gi] = sub_hit ? (ptr_ff[gi] - lit_wide) :
            (bus_hit ? hwdata[ADDR_W-1:0] : ptr_ff[gi]); // RULE_01
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ptr_ff[gi] <= PTR_RST;
            end else begin
               ptr_ff[gi] <= nxt_ptr[gi];
            end
         end
      end
   endgenerate

   assign stack_frame_pointer = ptr_ff[SEL_FRAME];

   // ==========================================================
   // Return
   // ==========================================================
   // Stack top is captured at the take edge, so the caller may move
   // it on at once without disturbing the loaded program counter
   logic pc_load_ff;
   logic [PC_W-1:0] pc_value_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_load_ff <= 1'b0;
         pc_value_ff <= PC_RST;
      end else begin
         pc_load_ff <= instr_take && is_return; // RULE_03
         if (instr_take && is_return) begin
            pc_value_ff <= return_stack_top; // RULE_03
         end
      end
   end

   assign pc_load = pc_load_ff;
   assign pc_value = pc_value_ff;

   // ==========================================================
   // Operand address mapping
   // ==========================================================
   logic [ADDR_W-1:0] map_comb;
   logic idx_comb;
   logic map_valid_ff;
   logic [ADDR_W-1:0] map_addr_ff;
   logic map_indexed_ff;
   logic map_wreg_ff;

   // An operand offered with a subtract sees the frame pointer from
   // before that subtract; the core must order such pairs itself
   index_addr_map i_index_addr_map (
      .ext_en(ext_en_ff), // RULE_06
      .file_addr(opnd_addr),
      .access_bit(opnd_access),
      .bank_sel(bank_select_value),
      .frame_ptr(ptr_ff[SEL_FRAME]),
      .eff_addr(map_comb),
      .indexed(idx_comb)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         map_valid_ff <= 1'b0;
         map_addr_ff <= PTR_RST;
         map_indexed_ff <= 1'b0;
         map_wreg_ff <= 1'b0;
      end else begin
         map_valid_ff <= opnd_valid;
         if (opnd_valid) begin
            map_addr_ff <= map_comb; // RULE_08 RULE_09
            map_indexed_ff <= idx_comb;
            map_wreg_ff <= !opnd_dest; // RULE_11
         end
      end
   end

   assign map_valid = map_valid_ff;
   assign map_addr = map_addr_ff;
   assign map_indexed = map_indexed_ff;
   assign map_to_wreg = map_wreg_ff;

   // ==========================================================
   // Event counters
   // ==========================================================
   // A count in the same cycle as a clearing write survives as 1
   logic [2:0] cnt_evt;
   logic [2:0] cnt_clr;
   logic [CNT_W-1:0] cnt_ff [3];

   assign cnt_evt = {opnd_valid && idx_comb, instr_take && is_sub_ptr,
                     instr_take && is_return};
   assign cnt_clr = {wr_mapcnt, wr_subcnt, wr_retcnt};

   generate
      for (gi = 0; gi < 3; gi++) begin : g_cnt
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt_ff[gi] <= CNT_RST;
            end else if (cnt_clr[gi]) begin
               cnt_ff[gi] <= {{(CNT_W-1){1'b0}}, cnt_evt[gi]};
            end else if (cnt_evt[gi]) begin
               cnt_ff[gi] <= cnt_ff[gi] + 1'b1;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read data
   // ==========================================================
   // Read data is picked in the data phase so a write just before
   // is already visible
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic [31:0] ptr_rd;
   logic ptr_rd_hit;

   assign status_word = {29'h00000000, pc_load_ff, ext_en_ff,
                         state_ff == ret_nop_st};

   always_comb begin
      ptr_rd = RDATA_ZERO;
      ptr_rd_hit = 1'b0;
      for (int i = 0; i < NUM_PTR; i++) begin
         if (reg_hit(rd_addr_ff, 8'(PTR0_OFS + 8'(i) * PTR_STRIDE))) begin
            ptr_rd = {20'h00000, ptr_ff[i]};
            ptr_rd_hit = 1'b1;
         end
      end
   end

   always_comb begin
      if (reg_hit(rd_addr_ff, CFG_OFS)) begin
         rd_mux = {31'h00000000, ext_en_ff};
      end else if (ptr_rd_hit) begin
         rd_mux = ptr_rd;
      end else if (reg_hit(rd_addr_ff, STATUS_OFS)) begin
         rd_mux = status_word;
      end else if (reg_hit(rd_addr_ff, RETCNT_OFS)) begin
         rd_mux = {16'h0000, cnt_ff[0]};
      end else if (reg_hit(rd_addr_ff, SUBCNT_OFS)) begin
         rd_mux = {16'h0000, cnt_ff[1]};
      end else if (reg_hit(rd_addr_ff, MAPCNT_OFS)) begin
         rd_mux = {16'h0000, cnt_ff[2]};
      end else if (reg_hit(rd_addr_ff, LASTMAP_OFS)) begin
         rd_mux = {18'h00000, map_wreg_ff, map_indexed_ff, map_addr_ff};
      end else begin
         rd_mux = RDATA_ZERO;
      end
   end

   assign hrdata = rd_pend_ff ? rd_mux : RDATA_ZERO;

endmodule

/* File: inc/core_ext_pkg.sv */
// Constants and types shared by the pointer subtract and indexed decode block
package core_ext_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 12;
   localparam int PC_W = 21;
   localparam int BANK_W = 4;
   localparam int CNT_W = 16;
   localparam int NUM_PTR = 3;

   // ==========================================================
   // Opcode fields
   localparam logic [7:0] OPC_SUB_PTR = 8'hE9;
   localparam logic [1:0] SEL_RETURN = 2'h3;
   localparam logic [1:0] SEL_FRAME = 2'h2;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 6;
   localparam int LIT_MSB = 5;

   // ==========================================================
   // Operand address mapping
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [11:0] ACCESS_LOW_BASE = 12'h000;
   localparam logic [11:0] ACCESS_HIGH_BASE = 12'hF00;
   localparam logic [11:0] ACCESS_HIGH_START = 12'h060;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] PTR0_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] RETCNT_OFS = 8'h14;
   localparam logic [7:0] SUBCNT_OFS = 8'h18;
   localparam logic [7:0] MAPCNT_OFS = 8'h1C;
   localparam logic [7:0] LASTMAP_OFS = 8'h20;
   localparam logic [7:0] PTR_STRIDE = 8'h04;

   // ==========================================================
   // Field positions and reset values
   localparam int CFG_EXT_BIT = 0;
   localparam logic CFG_EXT_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_EXT_BIT = 1;
   localparam int STAT_PCLOAD_BIT = 2;
   localparam int LASTMAP_IDX_BIT = 12;
   localparam int LASTMAP_WREG_BIT = 13;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [13:0] LASTMAP_RST = 14'h0000;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;

   // ==========================================================
   // Instruction sequencing
   typedef enum {exec_st, ret_nop_st} seq_state_t;

endpackage

/* File: logic/index_addr_map.sv */
// Operand file address to data memory address mapping
`timescale 1ns/1ps
module index_addr_map (
   input wire logic ext_en, // Extended set active
   input wire logic [7:0] file_addr, // Address field of the opcode
   input wire logic access_bit, // 0 access bank, 1 banked
   input wire logic [core_ext_pkg::BANK_W-1:0] bank_sel, // Bank select
   input wire logic [core_ext_pkg::ADDR_W-1:0] frame_ptr, // Frame pointer
   output logic [core_ext_pkg::ADDR_W-1:0] eff_addr, // Mapped address
   output logic indexed // Offset from frame pointer used
);
   import core_ext_pkg::*;

   logic [ADDR_W-1:0] wide_addr;
   logic [ADDR_W-1:0] frame_sum;
   logic [ADDR_W-1:0] banked_addr;
   logic [ADDR_W-1:0] access_addr;
   logic low_half;

   assign wide_addr = {4'h0, file_addr};
   assign low_half = (file_addr <= INDEX_LIMIT);
   // Sum wraps inside the data space
   assign frame_sum = frame_ptr + wide_addr; // RULE_13
   assign banked_addr = {bank_sel, file_addr}; // RULE_07
   // Upper half of the access bank stays literal in both modes
   assign access_addr = low_half ? (ACCESS_LOW_BASE | wide_addr) :
      (ACCESS_HIGH_BASE | (wide_addr - ACCESS_HIGH_START)); // RULE_07 RULE_12
   assign indexed = ext_en && !access_bit && low_half; // RULE_08 RULE_09
   // Zero frame pointer gives the literal access bank map
   assign eff_addr = access_bit ? banked_addr :
      (indexed ? frame_sum : access_addr); // RULE_10

endmodule

/* File: tb/psid_assertions.sv */
// Concurrent checks on the ports of the pointer subtract and decode block
`timescale 1ns/1ps
module psid_assertions (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset
   input wire logic instr_valid, // Word offered
   input wire logic [15:0] instr_word, // Program word
   input wire logic instr_ready, // Word taken
   input wire logic [core_ext_pkg::PC_W-1:0] return_stack_top, // Return
   input wire logic [core_ext_pkg::BANK_W-1:0] bank_select_value, // Bank
   input wire logic opnd_valid, // Operand offered
   input wire logic [7:0] opnd_addr, // File address
   input wire logic opnd_access, // Access bit
   input wire logic opnd_dest, // Destination bit
   input wire logic map_valid, // Mapped valid
   input wire logic [core_ext_pkg::ADDR_W-1:0] map_addr, // Mapped address
   input wire logic map_indexed, // Indexed flag
   input wire logic map_to_wreg, // To working register
   input wire logic pc_load, // PC load
   input wire logic [core_ext_pkg::PC_W-1:0] pc_value, // New PC
   input wire logic [core_ext_pkg::ADDR_W-1:0] stack_frame_pointer, // Frame
   input wire logic ext_enabled // Extension on
);
   import core_ext_pkg::*;
   // ==========================================================
   // Decode helpers
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire logic sub_op = instr_valid && instr_ready && ext_enabled
      && instr_word[15:8] == OPC_SUB_PTR;
   wire logic ret_op = sub_op && instr_word[SEL_MSB:SEL_LSB] == SEL_RETURN;
   wire logic frame_op = sub_op && instr_word[SEL_MSB:SEL_LSB] == SEL_FRAME;
   wire logic [11:0] lit = {6'h00, instr_word[LIT_MSB:0]};
   wire logic [11:0] ofs = {4'h0, opnd_addr};
   wire logic low_ofs = opnd_addr <= INDEX_LIMIT;
   wire logic [11:0] bank_addr = {bank_select_value, opnd_addr};
   // Upper access half sits at the top of data memory
   wire logic [11:0] acc_addr = low_ofs ? ofs
      : ACCESS_HIGH_BASE + ofs - ACCESS_HIGH_START;
   sequence s_ret_tail;
      pc_load && !instr_ready ##1 !pc_load && instr_ready;
   endsequence
   // ==========================================================
   // Properties
   a_ret_steps: assert property (ret_op |=> s_ret_tail)
      else $error("return did not take two cycles");
   a_ret_pc: assert property (ret_op |=>
      pc_value == $past(return_stack_top))
      else $error("return loaded wrong program counter");
   a_ret_frame: assert property (ret_op |=>
      stack_frame_pointer == $past(stack_frame_pointer) - $past(lit))
      else $error("return subtract wrong");
   a_sub_frame: assert property (frame_op |=> stack_frame_pointer ==
      $past(stack_frame_pointer) - $past(lit))
      else $error("frame subtract wrong");
   a_pc_quiet: assert property (!ret_op |=> !pc_load)
      else $error("program counter load without return");
   a_map_index: assert property (opnd_valid && !opnd_access
      && ext_enabled && low_ofs |=> map_valid && map_indexed
      && map_addr == $past(stack_frame_pointer) + $past(ofs))
      else $error("indexed address wrong");
   a_map_bank: assert property (opnd_valid && opnd_access |=>
      !map_indexed && map_addr == $past(bank_addr))
      else $error("banked address wrong");
   a_map_access: assert property (opnd_valid && !opnd_access
      && !(ext_enabled && low_ofs) |=> !map_indexed
      && map_addr == $past(acc_addr))
      else $error("access bank address wrong");
   a_map_dest: assert property (opnd_valid |=> map_valid
      && map_to_wreg == !$past(opnd_dest))
      else $error("destination select wrong");
endmodule
bind pointer_subtract_indexed_decode psid_assertions i_chk (
   .hclk(hclk), .hresetn(hresetn), .instr_valid(instr_valid),
   .instr_word(instr_word), .instr_ready(instr_ready),
   .return_stack_top(return_stack_top),
   .bank_select_value(bank_select_value), .opnd_valid(opnd_valid),
   .opnd_addr(opnd_addr), .opnd_access(opnd_access),
   .opnd_dest(opnd_dest), .map_valid(map_valid), .map_addr(map_addr),
   .map_indexed(map_indexed), .map_to_wreg(map_to_wreg),
   .pc_load(pc_load), .pc_value(pc_value),
   .stack_frame_pointer(stack_frame_pointer), .ext_enabled(ext_enabled));

/* File: tb/testbench.sv */
// Self-checking bench for the pointer subtract and indexed decode block
`timescale 1ns/1ps
module testbench;
   import core_ext_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [PC_W-1:0] return_stack_top = 21'h000000;
   logic [BANK_W-1:0] bank_select_value = 4'h0;
   logic opnd_valid = 1'b0;
   logic [7:0] opnd_addr = 8'h00;
   logic opnd_access = 1'b0;
   logic opnd_dest = 1'b0;
   logic hreadyout, hresp, instr_ready, map_valid, map_indexed;
   logic map_to_wreg, pc_load, ext_enabled;
   logic [31:0] hrdata;
   logic [ADDR_W-1:0] map_addr, stack_frame_pointer;
   logic [PC_W-1:0] pc_value;
   logic [31:0] rd;
   logic [7:0] pa;
   int mismatches = 0;
   int checked = 0;
   always #5 hclk = ~hclk;
   pointer_subtract_indexed_decode i_pointer_subtract_indexed_decode (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .return_stack_top(return_stack_top),
      .bank_select_value(bank_select_value), .opnd_valid(opnd_valid),
      .opnd_addr(opnd_addr), .opnd_access(opnd_access),
      .opnd_dest(opnd_dest), .map_valid(map_valid), .map_addr(map_addr),
      .map_indexed(map_indexed), .map_to_wreg(map_to_wreg),
      .pc_load(pc_load), .pc_value(pc_value),
      .stack_frame_pointer(stack_frame_pointer),
      .ext_enabled(ext_enabled));
   // ==========================================================
   // Shared tasks
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Waits for ready; only the watchdog ends a stuck wait
   task automatic wait_ready();
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
   endtask
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd,
                      output logic [31:0] rv);
      @(posedge hclk);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rv = hrdata;
   endtask
   task automatic exec(logic [15:0] w);
      @(posedge hclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge hclk);
      while (instr_ready !== 1'b1) begin
         @(posedge hclk);
      end
      instr_valid <= 1'b0;
   endtask
   task automatic map_chk(logic acc, logic [7:0] a, logic d,
                          logic [11:0] ea, logic ix);
      @(posedge hclk);
      opnd_valid <= 1'b1;
      opnd_access <= acc;
      opnd_addr <= a;
      opnd_dest <= d;
      @(posedge hclk);
      opnd_valid <= 1'b0;
      #1;
      check("map_valid", map_valid, 1'b1);
      check("map_addr", map_addr, ea);
      check("map_indexed", map_indexed, ix);
      check("map_to_wreg", map_to_wreg, !d);
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      rd = 32'h0;
      pa = 8'h00;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      check("ext_enabled", ext_enabled, 1'b1);
      bus(1'b0, CFG_OFS, 32'h0, rd);
      check("cfg", rd, 32'h1);
      bus(1'b0, 8'h40, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      check("hresp", hresp, 1'b0);
      check("hreadyout", hreadyout, 1'b1);
      $display("test reset done");
      for (int f = 0; f < 3; f++) begin
         pa = PTR0_OFS + 8'(f) * PTR_STRIDE;
         bus(1'b1, pa, 32'h3FF, rd);
         exec({OPC_SUB_PTR, 2'(f), 6'h23});
         bus(1'b0, pa, 32'h0, rd);
         check("ptr", rd, 32'h3DC);
      end
      bus(1'b1, PTR0_OFS, 32'h010, rd);
      exec({OPC_SUB_PTR, 2'h0, 6'h3F});
      bus(1'b0, PTR0_OFS, 32'h0, rd);
      check("ptr0 wrap", rd, 32'hFD1);
      $display("test pointer subtract done");
      return_stack_top <= 21'h1ABCDE;
      exec({OPC_SUB_PTR, SEL_RETURN, 6'h23});
      #1;
      check("pc_load", pc_load, 1'b1);
      check("pc_value", pc_value, 21'h1ABCDE);
      check("ready nop", instr_ready, 1'b0);
      check("frame", stack_frame_pointer, 12'h3B9);
      @(posedge hclk);
      #1;
      check("pc_load end", pc_load, 1'b0);
      check("ready back", instr_ready, 1'b1);
      bus(1'b0, PTR0_OFS + PTR_STRIDE, 32'h0, rd);
      check("ptr1 kept", rd, 32'h3DC);
      $display("test return done");
      bank_select_value <= 4'hA;
      map_chk(1'b0, 8'h5F, 1'b0, 12'h418, 1'b1);
      map_chk(1'b0, 8'h60, 1'b1, 12'hF00, 1'b0);
      map_chk(1'b1, 8'h20, 1'b0, 12'hA20, 1'b0);
      bus(1'b1, PTR0_OFS + 8'h08, 32'hFF0, rd);
      map_chk(1'b0, 8'h20, 1'b1, 12'h010, 1'b1);
      bus(1'b1, PTR0_OFS + 8'h08, 32'h000, rd);
      map_chk(1'b0, 8'h05, 1'b0, 12'h005, 1'b1);
      $display("test indexed map done");
      bus(1'b1, CFG_OFS, 32'h0, rd);
      bus(1'b1, PTR0_OFS + 8'h08, 32'h100, rd);
      #1;
      check("ext off", ext_enabled, 1'b0);
      exec({OPC_SUB_PTR, SEL_FRAME, 6'h01});
      bus(1'b0, PTR0_OFS + 8'h08, 32'h0, rd);
      check("ptr2 no sub", rd, 32'h100);
      map_chk(1'b0, 8'h10, 1'b0, 12'h010, 1'b0);
      map_chk(1'b0, 8'h7F, 1'b0, 12'hF1F, 1'b0);
      $display("test extension off done");
      end_of_test();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      mismatches++;
      end_of_test();
   end
endmodule
